/* File: hdl/drive_run_input_logic.v */
// Run-control logic: interprets controller logic inputs, exposes settings over AXI4-Lite.
// Assumes inputs are asynchronous pins; speed and torque values are signed 16-bit words.
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "drive_run_defs.vh"
module drive_run_input_logic
(
	input  wire        clk,
	input  wire        rst,
	input  wire        drive_enable,
	input  wire        run_in,
	input  wire        run_up,
	input  wire        run_down,
	input  wire        quick_stop,
	input  wire        overspeed_test_in,
	input  wire        pretorque_latch,
	input  wire        slowdown_threshold_in2,
	input  wire        recommended_travel,
	input  wire        scurve_sel0,
	input  wire        scurve_sel1,
	input  wire        serial_inspection_enable,
	input  wire        brake_lifting,
	input  wire        encoder_forward,
	input  wire        encoder_step,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         run_active,
	output reg         speed_negative,
	output reg         quick_stop_active,
	output reg  [1:0]  decel_set,
	output reg  [1:0]  scurve_set,
	output reg         slowdown2_active,
	output reg         inspection_run,
	output reg  [15:0] speed_ref,
	output reg  [15:0] overspeed_fault_level,
	output reg  [15:0] pretorque_hold
);
	localparam DECEL_SET_QUICK = 2'd2;
	localparam PIN_COUNT       = 15;
	wire [PIN_COUNT-1:0] lvl;
	wire [PIN_COUNT-1:0] rse;
	wire [PIN_COUNT-1:0] pins;
	assign pins = {run_in, drive_enable, encoder_step, encoder_forward, brake_lifting,
		serial_inspection_enable, scurve_sel1, scurve_sel0, recommended_travel,
		slowdown_threshold_in2, pretorque_latch, overspeed_test_in, quick_stop, run_down,
		run_up};
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi = gi + 1)
		begin : g_sync
			input_sync u_sync
			(
				.clk   (clk),
				.rst   (rst),
				.pin   (pins[gi]),
				.level (lvl[gi]),
				.rise  (rse[gi])
			);
		end
	endgenerate
	wire en_lvl  = lvl[13];
	wire run_lvl = lvl[14];
	wire up_l    = lvl[0];
	wire down_l  = lvl[1];
	wire qs_rise = rse[2];
	wire ot_rise = rse[3];
	wire pt_rise = rse[4];
	wire sd2_l   = lvl[5];
	wire rt_l    = lvl[6];
	wire sc0_l   = lvl[7];
	wire sc1_l   = lvl[8];
	wire insp_l  = lvl[9];
	wire brk_l   = lvl[10];
	wire encf_l  = lvl[11];
	wire encs_r  = rse[12];
	// Software-visible settings.
	reg  [1:0]  slowdown_threshold_mode;
	reg         ospd_src_ext;
	reg         dir_confirm;
	reg  [1:0]  serial_mode;
	reg         assign_refused;
	reg  [15:0] speed_cmd;
	reg  [15:0] overspeed_multiplier;
	reg  [15:0] overspeed_level;
	reg  [15:0] pretorque_cmd;
	reg  [15:0] third_decel_rate;
	reg  [7:0]  third_decel_jerk_entry;
	reg  [7:0]  third_decel_jerk_exit;
	// Run state.
	reg                    ospd_armed;
	reg                    ospd_in_run;
	reg                    qs_hold;
	reg                    travel_down;
	wire dir_conflict = up_l & down_l;
	wire dir_request  = (up_l | down_l) & ~dir_conflict;
	wire next_run     = en_lvl & (run_lvl | dir_request);
	// With confirmation on and recommended travel off, the analog command keeps its sign.
	wire next_neg     = rt_l ? travel_down :
		(dir_confirm ? speed_cmd[15] : (down_l & ~dir_conflict));
	wire [31:0] mult_speed = $signed(speed_cmd) * $signed({1'b0, overspeed_multiplier});
	wire [31:0] mult_level = overspeed_level * overspeed_multiplier;
	wire [15:0] base_speed = ospd_in_run ? mult_speed[23:8] : speed_cmd;
	wire [15:0] mag        = base_speed[15] ? (16'h0000 - base_speed) : base_speed;
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			run_active            <= 1'b0;
			speed_negative        <= 1'b0;
			quick_stop_active     <= 1'b0;
			decel_set             <= 2'd0;
			scurve_set            <= 2'd0;
			slowdown2_active      <= 1'b0;
			inspection_run        <= 1'b0;
			speed_ref             <= 16'h0000;
			overspeed_fault_level <= 16'h0000;
			pretorque_hold        <= 16'h0000;
			ospd_armed            <= 1'b0;
			ospd_in_run           <= 1'b0;
			qs_hold               <= 1'b0;
			travel_down           <= 1'b0;
		end
		else
		begin
			run_active     <= next_run;
			speed_negative <= next_neg;
			scurve_set     <= {sc1_l, sc0_l};
			slowdown2_active <= sd2_l & (slowdown_threshold_mode != `SLOWDOWN_THRESHOLD_MODE_ONE);
			inspection_run <= insp_l & (serial_mode == `SERIAL_MODE_TWO);
			if (pt_rise)
				pretorque_hold <= pretorque_cmd;
			// Arming is edge-only, so a held-true input cannot re-arm.
			if (ospd_src_ext && ot_rise && !ospd_in_run)
				ospd_armed <= 1'b1;
			if (!run_active && next_run && ospd_armed)
			begin
				ospd_in_run <= 1'b1;
				ospd_armed  <= 1'b0;
			end
			else if (run_active && !next_run)
				ospd_in_run <= 1'b0;
			if (!next_run)
				qs_hold <= 1'b0;
			else if (qs_rise)
				qs_hold <= 1'b1;
			quick_stop_active <= next_run & (qs_hold | qs_rise);
			decel_set <= (qs_hold | qs_rise) ? DECEL_SET_QUICK : {sc1_l, sc0_l};
			// Encoder drift while the brake lifts shows the load's free direction.
			if (run_active && rt_l && brk_l && encs_r)
				travel_down <= ~encf_l;
			if (!next_run || qs_hold || qs_rise)
				speed_ref <= 16'h0000;
			else
				speed_ref <= next_neg ? (16'h0000 - mag) : mag;
			overspeed_fault_level <= ospd_in_run ? mult_level[23:8] : overspeed_level;
		end
	end
	// AXI4-Lite slave: a write completes once address and data are both held.
	reg        aw_held;
	reg        w_held;
	reg [7:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		begin
			merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
		end
	endfunction

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready          <= 1'b0;
			s_axi_wready           <= 1'b0;
			s_axi_bvalid           <= 1'b0;
			s_axi_bresp            <= `OKAY;
			aw_held                <= 1'b0;
			w_held                 <= 1'b0;
			aw_addr                <= 8'h00;
			w_data                 <= 32'h0000_0000;
			w_strb                 <= 4'h0;
			slowdown_threshold_mode              <= `SLOWDOWN_THRESHOLD_MODE_ONE;
			ospd_src_ext           <= 1'b0;
			dir_confirm            <= 1'b0;
			serial_mode            <= 2'd0;
			assign_refused         <= 1'b0;
			speed_cmd              <= 16'h0000;
			overspeed_multiplier   <= `MULT_RESET;
			overspeed_level        <= 16'h0000;
			pretorque_cmd          <= 16'h0000;
			third_decel_rate       <= 16'h0000;
			third_decel_jerk_entry <= 8'h00;
			third_decel_jerk_exit  <= 8'h00;
		end
		else
		begin
			s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
			s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_held && w_held && !s_axi_bvalid)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `OKAY;
				case (aw_addr)
				`ADDR_CONFIG:
					if (w_strb[0])
					begin
						slowdown_threshold_mode    <= w_data[`CFG_SLOWDOWN_THRESHOLD_MODE_LSB+1:`CFG_SLOWDOWN_THRESHOLD_MODE_LSB];
						ospd_src_ext <= w_data[`CFG_OSPD_SRC_BIT];
						dir_confirm  <= w_data[`CFG_DIR_CONFIRM];
						serial_mode  <= w_data[`CFG_SERIAL_MODE_LSB+1:`CFG_SERIAL_MODE_LSB];
					end
				`ADDR_ASSIGN:
					if (w_strb[0])
					begin
						// Safe-off is hard-wired to one terminal; moving it is refused.
						assign_refused <= (w_data[3:0] != `SAFE_OFF_INPUT);
						if (w_data[3:0] != `SAFE_OFF_INPUT)
							s_axi_bresp <= `SLVERR;
					end
				`ADDR_SPEED_CMD:   speed_cmd <= merge16(speed_cmd, w_data, w_strb);
				`ADDR_MULT:
					overspeed_multiplier <= merge16(overspeed_multiplier, w_data, w_strb);
				`ADDR_OSPD_LEVEL:
					overspeed_level <= merge16(overspeed_level, w_data, w_strb);
				`ADDR_PRETRQ_CMD:  pretorque_cmd <= merge16(pretorque_cmd, w_data, w_strb);
				`ADDR_DECEL3:
				begin
					third_decel_rate <= merge16(third_decel_rate, w_data, w_strb);
					if (w_strb[2])
						third_decel_jerk_entry <= w_data[23:16];
					if (w_strb[3])
						third_decel_jerk_exit <= w_data[31:24];
				end
				`ADDR_PRETRQ_HOLD, `ADDR_STATUS, `ADDR_SPEED_OUT, `ADDR_FAULT_OUT: ;
				default: s_axi_bresp <= `SLVERR;
				endcase
			end
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `OKAY;
				case (s_axi_araddr[7:0])
				`ADDR_CONFIG: s_axi_rdata <= {26'd0, serial_mode, dir_confirm, ospd_src_ext,
					slowdown_threshold_mode};
				`ADDR_ASSIGN:      s_axi_rdata <= {27'd0, assign_refused, `SAFE_OFF_INPUT};
				`ADDR_SPEED_CMD:   s_axi_rdata <= {16'd0, speed_cmd};
				`ADDR_MULT:        s_axi_rdata <= {16'd0, overspeed_multiplier};
				`ADDR_OSPD_LEVEL:  s_axi_rdata <= {16'd0, overspeed_level};
				`ADDR_PRETRQ_CMD:  s_axi_rdata <= {16'd0, pretorque_cmd};
				`ADDR_PRETRQ_HOLD: s_axi_rdata <= {16'd0, pretorque_hold};
				`ADDR_STATUS: s_axi_rdata <= {20'd0, scurve_set, decel_set, inspection_run,
					slowdown2_active, travel_down, qs_hold, ospd_in_run, ospd_armed,
					speed_negative, run_active};
				`ADDR_SPEED_OUT:   s_axi_rdata <= {16'd0, speed_ref};
				`ADDR_FAULT_OUT:   s_axi_rdata <= {16'd0, overspeed_fault_level};
				`ADDR_DECEL3: s_axi_rdata <= {third_decel_jerk_exit, third_decel_jerk_entry,
					third_decel_rate};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `SLVERR;
				end
				endcase
			end
		end
	end

endmodule

/* File: hdl/drive_run_defs.vh */
// Constants for the drive run-input logic: register offsets, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`ifndef DRIVE_RUN_DEFS_VH
`define DRIVE_RUN_DEFS_VH

`define ADDR_CONFIG        8'h00
`define ADDR_ASSIGN        8'h04
`define ADDR_SPEED_CMD     8'h08
`define ADDR_MULT          8'h0C
`define ADDR_OSPD_LEVEL    8'h10
`define ADDR_PRETRQ_CMD    8'h14
`define ADDR_PRETRQ_HOLD   8'h18
`define ADDR_STATUS        8'h1C
`define ADDR_SPEED_OUT     8'h20
`define ADDR_FAULT_OUT     8'h24
`define ADDR_DECEL3        8'h28

`define CFG_SLOWDOWN_THRESHOLD_MODE_LSB  0
`define CFG_OSPD_SRC_BIT   2
`define CFG_DIR_CONFIRM    3
`define CFG_SERIAL_MODE_LSB 4
`define SLOWDOWN_THRESHOLD_MODE_ONE      2'd0
`define SERIAL_MODE_TWO    2'd2
`define SAFE_OFF_INPUT     4'd9

`define MULT_RESET         16'h0100
`define SLVERR             2'b10
`define OKAY               2'b00

`endif

/* File: hdl/input_sync.v */
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to clk; output is a clean level plus a rise pulse.
`timescale 1ns/1ps
module input_sync
(
	input  wire clk,
	input  wire rst,
	input  wire pin,
	output reg  level,
	output reg  rise
);
	reg s1;
	reg s2;
	reg s3;

	// Only the second and third stages are compared; the first feeds s2 alone.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
			rise  <= 1'b0;
		end
		else
		begin
			s1   <= pin;
			s2   <= s1;
			s3   <= s2;
			rise <= 1'b0;
			if (s2 == s3 && s3 != level)
			begin
				level <= s3;
				rise  <= s3;
			end
		end
	end
endmodule

/* File: tb/drive_run_checker.sv */
// Checker of the run-input block, watching its top-level ports only.
// Assumes pin changes reach the outputs within eight clocks.
`timescale 1ns/1ps
module drive_run_checker
(
	input wire        clk,
	input wire        rst,
	input wire        drive_enable,
	input wire        run_in,
	input wire        run_up,
	input wire        run_down,
	input wire        scurve_sel0,
	input wire        scurve_sel1,
	input wire        slowdown_threshold_in2,
	input wire        serial_inspection_enable,
	input wire        run_active,
	input wire        quick_stop_active,
	input wire [1:0]  decel_set,
	input wire [1:0]  scurve_set,
	input wire        slowdown2_active,
	input wire        inspection_run,
	input wire [15:0] speed_ref
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Two cycles are more than needed: the reference is zeroed on the same edge that raises the flag.
	property p_qs_zero;
		quick_stop_active [*2] |-> speed_ref == 16'h0000;
	endproperty
	a_qs_zero: assert property (p_qs_zero) else $error("speed not zero in quick stop");
	property p_qs_decel;
		quick_stop_active |-> decel_set == 2'h2;
	endproperty
	a_qs_decel: assert property (p_qs_decel) else $error("quick stop decel set wrong");
	property p_idle_zero;
		!run_active [*3] |-> speed_ref == 16'h0000;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("speed while not running");
	property p_no_enable;
		!drive_enable [*8] |=> !run_active;
	endproperty
	a_no_enable: assert property (p_no_enable) else $error("run without enable");
	property p_enable_only;
		(drive_enable && !run_in && !run_up && !run_down) [*8] |=> !run_active;
	endproperty
	a_enable_only: assert property (p_enable_only) else $error("enable started a run");
	property p_both_dirs;
		(run_up && run_down && !run_in) [*8] |=> !run_active;
	endproperty
	a_both_dirs: assert property (p_both_dirs) else $error("run with both directions");
	property p_scurve;
		(scurve_sel0 && scurve_sel1) [*8] |=> scurve_set == 2'h3;
	endproperty
	a_scurve: assert property (p_scurve) else $error("s-curve code wrong");
	property p_sd2_off;
		!slowdown_threshold_in2 [*8] |=> !slowdown2_active;
	endproperty
	a_sd2_off: assert property (p_sd2_off) else $error("slowdown 2 without input");
	property p_insp_off;
		!serial_inspection_enable [*8] |=> !inspection_run;
	endproperty
	a_insp_off: assert property (p_insp_off) else $error("inspection without input");
	c_qs: cover property (quick_stop_active);
	c_neg: cover property (run_active && speed_ref[15]);
	c_sd2: cover property (slowdown2_active);
	c_insp: cover property (inspection_run);
endmodule
bind drive_run_input_logic drive_run_checker i_drive_run_checker
(
	.clk, .rst, .drive_enable, .run_in, .run_up, .run_down, .scurve_sel0, .scurve_sel1,
	.slowdown_threshold_in2, .serial_inspection_enable, .run_active, .quick_stop_active,
	.decel_set, .scurve_set, .slowdown2_active, .inspection_run, .speed_ref
);

/* File: tb/controller_model.sv */
// Lift controller model: drives the discrete logic pins from a requested pattern.
// Assumes the bench changes the request just after a rising edge.
`timescale 1ns/1ps
module controller_model
(
	input  wire        clk,
	input  wire [14:0] want,
	output reg  [14:0] pins
);
	initial pins = 15'h0000;
	// Pins move on the clock only, so each request reaches the block one edge later.
	always @(posedge clk)
	begin
		pins <= want;
	end
endmodule

/* File: tb/testbench.sv */
// Testbench of the run-input block: pins via the controller model, settings via AXI4-Lite.
// Assumes pin changes settle at the outputs within twelve clocks.
`timescale 1ns/1ps
`include "drive_run_defs.vh"
module testbench;
	localparam EN = 14, RUN = 13, UP = 12, DN = 11, QS = 10, OT = 9, PL = 8, SD = 7;
	localparam RT = 6, S0 = 5, S1 = 4, SI = 3, BL = 2, EF = 1, ES = 0;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [14:0] want = 15'h0000;
	wire  [14:0] pins;
	wire         drive_enable, run_in, run_up, run_down, quick_stop, overspeed_test_in;
	wire         pretorque_latch, slowdown_threshold_in2, recommended_travel, scurve_sel0;
	wire         scurve_sel1, serial_inspection_enable, brake_lifting, encoder_forward;
	wire         encoder_step;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rd_data;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp, decel_set, scurve_set;
	wire  [31:0] s_axi_rdata;
	wire         run_active, speed_negative, quick_stop_active, slowdown2_active;
	wire         inspection_run;
	wire  [15:0] speed_ref, overspeed_fault_level, pretorque_hold;
	int          miscompares = 0;
	int          compares = 0;
	assign {drive_enable, run_in, run_up, run_down, quick_stop, overspeed_test_in,
		pretorque_latch, slowdown_threshold_in2, recommended_travel, scurve_sel0,
		scurve_sel1, serial_inspection_enable, brake_lifting, encoder_forward,
		encoder_step} = pins;
	controller_model i_controller_model (.clk, .want, .pins);
	drive_run_input_logic i_drive_run_input_logic
	(
		.clk, .rst, .drive_enable, .run_in, .run_up, .run_down, .quick_stop,
		.overspeed_test_in, .pretorque_latch, .slowdown_threshold_in2, .recommended_travel,
		.scurve_sel0, .scurve_sel1, .serial_inspection_enable, .brake_lifting,
		.encoder_forward, .encoder_step, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_active,
		.speed_negative, .quick_stop_active, .decel_set, .scurve_set, .slowdown2_active,
		.inspection_run, .speed_ref, .overspeed_fault_level, .pretorque_hold
	);
	initial
	begin
		forever #50 clk = ~clk;
	end
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task conclude;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task settle;
		repeat (12) @(posedge clk);
	endtask
	task pin(input int idx, input logic v);
		@(posedge clk);
		want[idx] <= v;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("bresp", 32'(s_axi_bresp), 32'(er));
	endtask
	task rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd_data = s_axi_rdata;
		s_axi_rready <= 1'b0;
		check("rresp", 32'(s_axi_rresp), 32'(er));
	endtask
	task t_regs;
		rd(`ADDR_ASSIGN, `OKAY);
		check("assign", rd_data, 32'h0000_0009);
		rd(`ADDR_MULT, `OKAY);
		check("mult", rd_data, 32'h0000_0100);
		wr(`ADDR_ASSIGN, 32'h0000_0005, `SLVERR);
		rd(`ADDR_ASSIGN, `OKAY);
		check("assign", rd_data, 32'h0000_0019);
		wr(`ADDR_ASSIGN, 32'h0000_0009, `OKAY);
		rd(8'h40, `SLVERR);
		wr(8'h40, 32'h0000_0001, `SLVERR);
		$display("registers done");
	endtask
	task t_run;
		wr(`ADDR_SPEED_CMD, 32'h0000_0100, `OKAY);
		pin(RUN, 1);
		settle;
		check("run", 32'(run_active), 32'h0000_0000);
		pin(EN, 1);
		settle;
		check("run", 32'(run_active), 32'h0000_0001);
		check("speed", 32'(speed_ref), 32'h0000_0100);
		pin(RUN, 0);
		settle;
		check("run", 32'(run_active), 32'h0000_0000);
		pin(DN, 1);
		settle;
		check("neg", 32'(speed_negative), 32'h0000_0001);
		check("speed", 32'(speed_ref), 32'h0000_FF00);
		pin(UP, 1);
		settle;
		check("run", 32'(run_active), 32'h0000_0000);
		pin(DN, 0);
		settle;
		check("speed", 32'(speed_ref), 32'h0000_0100);
		pin(UP, 0);
		wr(`ADDR_CONFIG, 32'h0000_0008, `OKAY);
		pin(DN, 1);
		settle;
		check("speed", 32'(speed_ref), 32'h0000_0100);
		check("run", 32'(run_active), 32'h0000_0001);
		pin(DN, 0);
		wr(`ADDR_CONFIG, 32'h0000_0000, `OKAY);
		$display("run commands done");
	endtask
	task t_qs;
		wr(`ADDR_DECEL3, 32'h0003_0201, `OKAY);
		rd(`ADDR_DECEL3, `OKAY);
		check("decel3", rd_data, 32'h0003_0201);
		pin(RUN, 1);
		pin(QS, 1);
		settle;
		check("qs", 32'(quick_stop_active), 32'h0000_0001);
		check("decel", 32'(decel_set), 32'h0000_0002);
		pin(QS, 0);
		settle;
		check("speed", 32'(speed_ref), 32'h0000_0000);
		pin(RUN, 0);
		settle;
		check("qs", 32'(quick_stop_active), 32'h0000_0000);
		pin(RUN, 1);
		settle;
		check("speed", 32'(speed_ref), 32'h0000_0100);
		pin(QS, 1);
		settle;
		check("qs", 32'(quick_stop_active), 32'h0000_0001);
		check("speed", 32'(speed_ref), 32'h0000_0000);
		pin(QS, 0);
		pin(EN, 0);
		settle;
		check("qs", 32'(quick_stop_active), 32'h0000_0000);
		pin(RUN, 0);
		pin(EN, 1);
		$display("quick stop done");
	endtask
	task t_ospd;
		wr(`ADDR_CONFIG, 32'h0000_0004, `OKAY);
		wr(`ADDR_MULT, 32'h0000_0200, `OKAY);
		wr(`ADDR_OSPD_LEVEL, 32'h0000_0400, `OKAY);
		for (int k = 0; k < 3; k++)
		begin
			if (k != 1) pin(OT, 0);
			settle;
			pin(OT, 1);
			pin(RUN, 1);
			settle;
			check("speed", 32'(speed_ref), k == 1 ? 32'h0000_0100 : 32'h0000_0200);
			check("level", 32'(overspeed_fault_level), k == 1 ? 32'h0000_0400 : 32'h0000_0800);
			pin(RUN, 0);
			settle;
			check("level", 32'(overspeed_fault_level), 32'h0000_0400);
		end
		pin(OT, 0);
		wr(`ADDR_CONFIG, 32'h0000_0000, `OKAY);
		$display("overspeed test done");
	endtask
	task t_misc;
		wr(`ADDR_PRETRQ_CMD, 32'h0000_1234, `OKAY);
		pin(PL, 1);
		settle;
		wr(`ADDR_PRETRQ_CMD, 32'h0000_5678, `OKAY);
		settle;
		check("hold", 32'(pretorque_hold), 32'h0000_1234);
		pin(PL, 0);
		settle;
		pin(PL, 1);
		settle;
		rd(`ADDR_PRETRQ_HOLD, `OKAY);
		check("hold", rd_data, 32'h0000_5678);
		for (int i = 0; i < 4; i++)
		begin
			pin(S0, i[0]);
			pin(S1, i[1]);
			settle;
			check("scurve", 32'(scurve_set), 32'(i));
		end
		pin(SD, 1);
		pin(SI, 1);
		settle;
		check("sd2", 32'(slowdown2_active), 32'h0000_0000);
		check("insp", 32'(inspection_run), 32'h0000_0000);
		wr(`ADDR_CONFIG, 32'h0000_0021, `OKAY);
		settle;
		check("sd2", 32'(slowdown2_active), 32'h0000_0001);
		check("insp", 32'(inspection_run), 32'h0000_0001);
		wr(`ADDR_CONFIG, 32'h0000_0000, `OKAY);
		pin(RT, 1);
		pin(RUN, 1);
		pin(BL, 1);
		for (int d = 0; d < 2; d++)
		begin
			pin(EF, d[0]);
			pin(ES, 1);
			settle;
			pin(ES, 0);
			settle;
			rd(`ADDR_STATUS, `OKAY);
			check("travel", 32'(rd_data[5]), 32'(1 - d));
			check("neg", 32'(speed_negative), 32'(1 - d));
		end
		$display("misc inputs done");
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_run;
		t_qs;
		t_ospd;
		t_misc;
		conclude;
	end
	// The whole run takes well under a thousand clocks; this bound only catches a hung handshake.
	initial
	begin
		repeat (30000) @(posedge clk);
		miscompares++;
		conclude;
	end
endmodule
